//--- src/cscp_pkg.sv
package cscp_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int FRAME_W = 12;
    localparam int NUM_REGS = 6;
    localparam logic [3:0] REG_DAC_TEST = 4'h0;
    localparam logic [3:0] REG_M_DIV = 4'h1;
    localparam logic [3:0] REG_N_DIV_OSC = 4'h2;
    localparam logic [3:0] REG_PRECOMP = 4'h3;
    localparam logic [3:0] REG_MARGIN = 4'h4;
    localparam logic [3:0] REG_TEST_MUX = 4'h5;
    localparam int DAC_LSB = 0;
    localparam int DAC_W = 5;
    localparam int TEST_MODE_BIT = 5;
    localparam int BYPASS_BIT = 6;
    localparam int CLEAR_BIT = 7;
    localparam int SEP_OSC_BIT = 0;
    localparam int SYN_OSC_BIT = 7;
    localparam int ERASE_DIS_BIT = 4;
    localparam int DEC_TEST_BIT = 5;
    localparam int PRECOMP_BYP_BIT = 6;
    localparam int ENC_BYP_BIT = 7;
    localparam logic [7:0] RESET_VAL = 8'hFF;
    localparam logic [7:0] MUX_RESET_VAL = 8'hF0;
    localparam logic [7:0] MUX_USED_MASK = 8'hF0;
    localparam int SETTLE_NS = 40;
    localparam int CLK_NS = 20;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = 18;
    localparam logic [4:0] WAKE_W = 5'h12;
endpackage

//--- src/cscp_sync.sv
`timescale 1ns/1ns
module cscp_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    input wire logic rst_val_in,
    output logic q_out
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= rst_val_in;
            sync_q <= rst_val_in;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end
    assign q_out = sync_q;
endmodule

//--- src/cscp_power.sv
`timescale 1ns/1ns
module cscp_power (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic nap_n_in,
    input wire logic wgate_n_in,
    input wire logic rgate_n_in,
    output logic enc_off_out,
    output logic precomp_off_out,
    output logic dec_off_out
);
    logic nap_n_s;
    logic wgate_n_s;
    logic rgate_n_s;
    logic enc_d;
    logic dec_d;
    logic enc_q;
    logic dec_q;
    cscp_sync u_sync_nap (.clk_in(clk_in), .rst_in(rst_in), .d_in(nap_n_in),
        .rst_val_in(1'b1), .q_out(nap_n_s));
    cscp_sync u_sync_wgate (.clk_in(clk_in), .rst_in(rst_in), .d_in(wgate_n_in),
        .rst_val_in(1'b1), .q_out(wgate_n_s));
    cscp_sync u_sync_rgate (.clk_in(clk_in), .rst_in(rst_in), .d_in(rgate_n_in),
        .rst_val_in(1'b1), .q_out(rgate_n_s));
    always_comb begin
        enc_d = !nap_n_s && wgate_n_s; // [RQ13] [RQ14]
        dec_d = !nap_n_s && rgate_n_s; // [RQ13] [RQ15]
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enc_q <= 1'b0;
            dec_q <= 1'b0;
        end else begin
            enc_q <= enc_d;
            dec_q <= dec_d;
        end
    end
    assign enc_off_out = enc_q;
    assign precomp_off_out = enc_q;
    assign dec_off_out = dec_q;
    nap_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ13]
        nap_n_s |=> !enc_q && !dec_q) else $error("nap off but power reduced");
    nap_enc_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ14]
        (!nap_n_s && wgate_n_s) |=> enc_q) else $error("encoder not off");
    nap_dec_a: assert property (@(posedge clk_in) disable iff (rst_in) // [RQ15]
        (!nap_n_s && rgate_n_s) |=> dec_q) else $error("decoder not off");
endmodule

//--- src/cscp_port.sv
`timescale 1ns/1ns
// How it works
// (RQ1) Data bits sampled on rising shift clock, LSB first
// (RQ2) Four address bits follow, LSB first
// (RQ3) Unclocked low data line marks a write
// (RQ4) Enable release latches data into addressed register
// (RQ5) One write frame per register
// (RQ6) Read: address in, unclocked high line
// (RQ7) First release drives output with bit 0
// (RQ8) Each strobe advances output; seven reach MSB
// (RQ9) Four more strobes shift out address
// (RQ10) Low line then second release tristates output
// (RQ11) Sleep disables port; reprogram after wake
// (RQ12) Write output ignored eighteen clocks after wake
// (RQ13) Nap high means no power reduction
// (RQ14) Nap with write gate off: encoder, precomp off
// (RQ15) Nap with read gate off: decoder off
// (RQ16) Register 0: DAC code, test, bypass, clear
// (RQ17) Option controls act only with option pin low; erase disable (register 4 bit 4) ignores the pin
// (RQ18) Test bit low enables phase/frequency mode
// (RQ19) Bypass bit low selects external oscillators
// (RQ20) Clear bit low holds dividers at zero
// (RQ21) Typical DAC and divider settings by controller
// (RQ22) Typical precomp and margin settings by controller
// (RQ23) Shift edges ignored while enable deasserted
module cscp_port (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic serial_frame_select_n_in,
    input wire logic serial_input_line_in,
    input wire logic serial_shift_clock_in,
    input wire logic option_enable_n_in,
    input wire logic sleep_in,
    input wire logic low_power_request_n_in,
    input wire logic write_gate_n_in,
    input wire logic read_gate_n_in,
    output logic serial_readback_line_out,
    output logic serial_readback_line_oe_out,
    output logic [cscp_pkg::DAC_W-1:0] dac_code_out,
    output logic phase_freq_detector_mode_out,
    output logic divider_bypass_out,
    output logic divider_clear_out,
    output logic [7:0] synth_m_divider_out,
    output logic [5:0] synth_n_divider_out,
    output logic synth_osc_select_out,
    output logic separator_osc_select_out,
    output logic [7:0] write_precompensation_out,
    output logic [3:0] margin_dac_out,
    output logic erase_signal_disable_out,
    output logic decoder_test_input_out,
    output logic precomp_bypass_out,
    output logic encoder_bypass_out,
    output logic [3:0] test_mux_ctrl_out,
    output logic compensated_write_valid_out,
    output logic encoder_off_out,
    output logic precomp_off_out,
    output logic decoder_off_out
);
    import cscp_pkg::*;

    typedef enum logic [3:0] {
        CSCP_IDLE = 4'b0001,
        CSCP_SHIFT = 4'b0010,
        CSCP_READ_WAIT = 4'b0100,
        CSCP_READ_OUT = 4'b1000
    } cscp_state_t;

    logic sel_n_s;
    logic din_s;
    logic sclk_s;
    logic opt_n_s;
    logic sleep_s;

    cscp_sync u_sync_sel (.clk_in(clock_in), .rst_in(rst_in), .d_in(serial_frame_select_n_in),
        .rst_val_in(1'b1), .q_out(sel_n_s));
    cscp_sync u_sync_din (.clk_in(clock_in), .rst_in(rst_in), .d_in(serial_input_line_in),
        .rst_val_in(1'b1), .q_out(din_s));
    cscp_sync u_sync_sclk (.clk_in(clock_in), .rst_in(rst_in), .d_in(serial_shift_clock_in),
        .rst_val_in(1'b1), .q_out(sclk_s));
    cscp_sync u_sync_opt (.clk_in(clock_in), .rst_in(rst_in), .d_in(option_enable_n_in),
        .rst_val_in(1'b1), .q_out(opt_n_s));
    cscp_sync u_sync_sleep (.clk_in(clock_in), .rst_in(rst_in), .d_in(sleep_in),
        .rst_val_in(1'b1), .q_out(sleep_s));

    cscp_power u_power (
        .clk_in(clock_in),
        .rst_in(rst_in),
        .nap_n_in(low_power_request_n_in),
        .wgate_n_in(write_gate_n_in),
        .rgate_n_in(read_gate_n_in),
        .enc_off_out(encoder_off_out),
        .precomp_off_out(precomp_off_out),
        .dec_off_out(decoder_off_out)
    );

    function automatic logic opt_ctl(input logic bit_v, input logic opt_n);
        opt_ctl = !bit_v && !opt_n; // [RQ17]
    endfunction

    cscp_state_t state_q, state_d;
    logic sel_n_q, sclk_q;
    logic [FRAME_W-1:0] shift_q, shift_d;
    logic [3:0] cnt_q, cnt_d;
    logic [DATA_W-1:0] regs_q [NUM_REGS];
    logic [DATA_W-1:0] regs_d [NUM_REGS];
    logic [FRAME_W-1:0] out_q, out_d;
    logic oe_q, oe_d;
    logic [1:0] settle_q, settle_d;
    logic [4:0] wake_q, wake_d;
    logic sclk_rise, sel_fall, sel_rise;
    logic [ADDR_W-1:0] addr_w, raddr_w;
    logic [DATA_W-1:0] rdata_w;

    assign sclk_rise = sclk_s && !sclk_q;
    assign sel_fall = !sel_n_s && sel_n_q;
    assign sel_rise = sel_n_s && !sel_n_q;
    assign addr_w = shift_q[FRAME_W-1 -: ADDR_W];
    assign raddr_w = shift_q[FRAME_W-1 -: ADDR_W];
    assign rdata_w = (raddr_w < NUM_REGS[ADDR_W-1:0]) ? regs_q[raddr_w[2:0]] : 8'h00;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d = cnt_q;
        out_d = out_q;
        oe_d = oe_q;
        settle_d = settle_q;
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        unique case (state_q)
            CSCP_IDLE: begin
                if (sel_fall && !sleep_s) begin // [RQ11]
                    state_d = CSCP_SHIFT;
                    cnt_d = 4'h0;
                end
            end
            CSCP_SHIFT: begin
                if (sclk_rise && !sel_n_s && cnt_q < FRAME_W[3:0]) begin // [RQ23]
                    shift_d = {din_s, shift_q[FRAME_W-1:1]}; // [RQ1] [RQ2]
                    cnt_d = cnt_q + 4'h1;
                end
                if (sel_rise) begin
                    state_d = CSCP_IDLE;
                    if (din_s && cnt_q == ADDR_W[3:0]) begin // [RQ6]
                        out_d = {raddr_w, rdata_w};
                        oe_d = 1'b1; // [RQ7]
                        settle_d = SETTLE_CYC[1:0];
                        state_d = CSCP_READ_WAIT;
                    end else if (!din_s && cnt_q == FRAME_W[3:0]
                                 && addr_w < NUM_REGS[ADDR_W-1:0]) begin
                        regs_d[addr_w[2:0]] = shift_q[DATA_W-1:0]; // [RQ3] [RQ4] [RQ5]
                        // Unused low bits of the test mux register read back as zero
                        if (addr_w == REG_TEST_MUX) begin
                            regs_d[addr_w[2:0]] = shift_q[DATA_W-1:0] & MUX_USED_MASK;
                        end
                    end
                end
            end
            CSCP_READ_WAIT: begin
                if (settle_q != 2'h0) begin
                    settle_d = settle_q - 2'h1;
                end
                if (sel_fall) begin
                    state_d = CSCP_READ_OUT;
                end
            end
            CSCP_READ_OUT: begin
                if (sclk_rise && !sel_n_s) begin
                    out_d = {1'b0, out_q[FRAME_W-1:1]}; // [RQ8] [RQ9]
                end
                if (sel_rise && !din_s) begin
                    oe_d = 1'b0; // [RQ10]
                    state_d = CSCP_IDLE;
                end
            end
            default: begin
                state_d = CSCP_IDLE;
            end
        endcase
    end

    always_comb begin
        wake_d = wake_q;
        if (sleep_s) begin
            wake_d = WAKE_W; // [RQ12]
        end else if (wake_q != 5'h00) begin
            wake_d = wake_q - 5'h01;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= CSCP_IDLE;
            sel_n_q <= 1'b1;
            sclk_q <= 1'b1;
            shift_q <= '0;
            cnt_q <= 4'h0;
            out_q <= '0;
            oe_q <= 1'b0;
            settle_q <= 2'h0;
            wake_q <= 5'h00;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= (i == NUM_REGS - 1) ? MUX_RESET_VAL : RESET_VAL;
            end
        end else begin
            state_q <= sleep_s ? CSCP_IDLE : state_d; // [RQ11]
            sel_n_q <= sel_n_s;
            sclk_q <= sclk_s;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
            oe_q <= sleep_s ? 1'b0 : oe_d;
            settle_q <= settle_d;
            wake_q <= wake_d;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    logic [7:0] r0_q, r2_q, r4_q;
    assign r0_q = regs_q[0];
    assign r2_q = regs_q[2];
    assign r4_q = regs_q[4];

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            serial_readback_line_out <= 1'b0;
            serial_readback_line_oe_out <= 1'b0;
            dac_code_out <= '0;
            phase_freq_detector_mode_out <= 1'b0;
            divider_bypass_out <= 1'b0;
            divider_clear_out <= 1'b0;
            synth_m_divider_out <= '0;
            synth_n_divider_out <= '0;
            synth_osc_select_out <= 1'b0;
            separator_osc_select_out <= 1'b0;
            write_precompensation_out <= '0;
            margin_dac_out <= '0;
            erase_signal_disable_out <= 1'b0;
            decoder_test_input_out <= 1'b0;
            precomp_bypass_out <= 1'b0;
            encoder_bypass_out <= 1'b0;
            test_mux_ctrl_out <= '0;
            compensated_write_valid_out <= 1'b0;
        end else begin
            serial_readback_line_out <= (state_d == CSCP_READ_WAIT && settle_d != 2'h0)
                ? 1'b0 : out_d[0]; // [RQ7]
            serial_readback_line_oe_out <= sleep_s ? 1'b0 : oe_d;
            dac_code_out <= r0_q[DAC_LSB +: DAC_W]; // [RQ16]
            phase_freq_detector_mode_out <= opt_ctl(r0_q[TEST_MODE_BIT], opt_n_s); // [RQ18]
            divider_bypass_out <= opt_ctl(r0_q[BYPASS_BIT], opt_n_s); // [RQ19]
            divider_clear_out <= opt_ctl(r0_q[CLEAR_BIT], opt_n_s); // [RQ20]
            synth_m_divider_out <= regs_q[1];
            synth_n_divider_out <= r2_q[6:1];
            synth_osc_select_out <= opt_ctl(r2_q[SYN_OSC_BIT], opt_n_s);
            separator_osc_select_out <= opt_ctl(r2_q[SEP_OSC_BIT], opt_n_s);
            write_precompensation_out <= regs_q[3];
            margin_dac_out <= r4_q[3:0];
            erase_signal_disable_out <= !r4_q[ERASE_DIS_BIT];
            decoder_test_input_out <= opt_ctl(r4_q[DEC_TEST_BIT], opt_n_s);
            precomp_bypass_out <= opt_ctl(r4_q[PRECOMP_BYP_BIT], opt_n_s);
            encoder_bypass_out <= opt_ctl(r4_q[ENC_BYP_BIT], opt_n_s);
            test_mux_ctrl_out <= regs_q[5][7:4];
            compensated_write_valid_out <= !sleep_s && wake_d == 5'h00; // [RQ12]
        end
    end

    opt_gate_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ17]
        opt_n_s |=> !divider_clear_out && !divider_bypass_out)
        else $error("option control active with pin high");
    clear_bit_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ20]
        (!opt_n_s && !r0_q[CLEAR_BIT]) |=> divider_clear_out)
        else $error("divider clear missing");
    test_bit_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ18]
        (!opt_n_s && !r0_q[TEST_MODE_BIT]) |=> phase_freq_detector_mode_out)
        else $error("detector mode missing");
    edge_ignore_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ23]
        (sel_n_s && state_q == CSCP_SHIFT) |=> cnt_q == $past(cnt_q))
        else $error("shift while disabled");
    read_end_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ10]
        (state_q == CSCP_READ_OUT && sel_rise && !din_s && !sleep_s)
        |=> ##1 !serial_readback_line_oe_out) else $error("readback not tristated");
    read_hold_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ10]
        (state_q == CSCP_READ_OUT && !sel_rise && !sleep_s) |=> serial_readback_line_oe_out)
        else $error("readback released early");
    read_start_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ7]
        (state_q == CSCP_SHIFT && sel_rise && din_s && cnt_q == 4'h4 && !sleep_s)
        |=> ##1 serial_readback_line_oe_out) else $error("readback not driven");
    settle_low_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ7]
        (state_q == CSCP_SHIFT && sel_rise && din_s && cnt_q == 4'h4 && !sleep_s)
        |=> !serial_readback_line_out) else $error("readback not held during settling");
    sleep_idle_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ11]
        sleep_s |=> state_q == CSCP_IDLE && !serial_readback_line_oe_out)
        else $error("port active during sleep");
    wake_hold_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ12]
        $fell(sleep_s) |=> !compensated_write_valid_out [*8])
        else $error("write output valid too early");
    write_frame_a: assert property (@(posedge clock_in) disable iff (rst_in) // [RQ4]
        (state_q == CSCP_SHIFT && sel_rise && !din_s && cnt_q == 4'hC && addr_w == 4'h1
         && !sleep_s) |=> regs_q[1] == $past(shift_q[7:0]))
        else $error("write not latched");
endmodule

//--- dv/cscp_ctrl_model.sv
`timescale 1ns/1ns
module cscp_ctrl_model (
    input wire logic clock_in,
    input wire logic readback_in,
    input wire logic readback_oe_in,
    output logic frame_select_n_out,
    output logic data_out,
    output logic shift_clock_out
);
    import cscp_pkg::*;
    logic line_w;
    // A released line shows the inverse, so reading it while idle fails
    assign line_w = readback_oe_in ? readback_in : !readback_in;
    initial begin
        frame_select_n_out = 1'b1;
        data_out = 1'b0;
        shift_clock_out = 1'b0;
    end
    // Every pin level stands four clocks before the next change
    task automatic hold();
        repeat (4) @(posedge clock_in);
    endtask
    task automatic strobe();
        shift_clock_out <= 1'b1;
        hold();
        shift_clock_out <= 1'b0;
        hold();
    endtask
    task automatic idle_strobes();
        @(posedge clock_in);
        repeat (3) strobe();
    endtask
    task automatic write_frame(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        logic [FRAME_W-1:0] frame;
        frame = {addr, data};
        @(posedge clock_in);
        frame_select_n_out <= 1'b0;
        hold();
        for (int i = 0; i < FRAME_W; i++) begin
            data_out <= frame[i];
            hold();
            strobe();
        end
        data_out <= 1'b0;
        hold();
        frame_select_n_out <= 1'b1;
        hold();
        hold();
    endtask
    task automatic read_frame(input logic [ADDR_W-1:0] addr, output logic [FRAME_W-1:0] bits,
                              output logic oe_on, output logic oe_off);
        int n;
        @(posedge clock_in);
        frame_select_n_out <= 1'b0;
        hold();
        for (int i = 0; i < ADDR_W; i++) begin
            data_out <= addr[i];
            hold();
            strobe();
        end
        data_out <= 1'b1;
        hold();
        frame_select_n_out <= 1'b1;
        n = 0;
        while (readback_oe_in !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            n++;
        end
        oe_on = readback_oe_in;
        hold();
        bits[0] = line_w;
        frame_select_n_out <= 1'b0;
        hold();
        for (int i = 1; i < FRAME_W; i++) begin
            strobe();
            bits[i] = line_w;
        end
        data_out <= 1'b0;
        hold();
        frame_select_n_out <= 1'b1;
        hold();
        hold();
        oe_off = readback_oe_in;
    endtask
endmodule

//--- dv/channel_serial_config_port_bench.sv
`timescale 1ns/1ns
module channel_serial_config_port_bench;
    import cscp_pkg::*;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic option_enable_n_in = 1'b1;
    logic sleep_in = 1'b0;
    logic low_power_request_n_in = 1'b1;
    logic write_gate_n_in = 1'b1;
    logic read_gate_n_in = 1'b1;
    wire logic sel_n, sdata, sclk, rb, rb_oe;
    wire logic phase_freq_detector, byp, clr, sosc, rosc, erase, dtest, pbyp, ebyp, valid, enc_off, pc_off, dec_off;
    wire logic [4:0] dac;
    wire logic [7:0] m_div, write_precompensation;
    wire logic [5:0] n_div;
    wire logic [3:0] margin, mux;
    wire logic [42:0] obs;
    int bad_count = 0;
    int compares = 0;
    logic [11:0] bits;
    logic oe_on, oe_off;
    logic [7:0] typ [NUM_REGS] = '{8'hF0, 8'h7F, 8'hBF, 8'h88, 8'hF8, 8'h00};
    localparam logic [42:0] OBS_TYP = {5'h10, 3'h0, 8'h7F, 6'h1F, 2'h0, 8'h88, 4'h8, 3'h0, 4'h0};
    localparam logic [42:0] OBS_OPT = {5'h10, 3'h7, 8'h7F, 6'h1F, 2'h3, 8'h88, 4'h8, 3'h7, 4'hA};
    assign obs = {dac, phase_freq_detector, byp, clr, m_div, n_div, sosc, rosc, write_precompensation, margin, dtest, pbyp, ebyp, mux};
    cscp_port dut_u (.clock_in(clock_in), .rst_in(rst_in), .serial_frame_select_n_in(sel_n),
        .serial_input_line_in(sdata), .serial_shift_clock_in(sclk),
        .option_enable_n_in(option_enable_n_in), .sleep_in(sleep_in),
        .low_power_request_n_in(low_power_request_n_in), .write_gate_n_in(write_gate_n_in),
        .read_gate_n_in(read_gate_n_in), .serial_readback_line_out(rb),
        .serial_readback_line_oe_out(rb_oe), .dac_code_out(dac),
        .phase_freq_detector_mode_out(phase_freq_detector), .divider_bypass_out(byp), .divider_clear_out(clr),
        .synth_m_divider_out(m_div), .synth_n_divider_out(n_div), .synth_osc_select_out(sosc),
        .separator_osc_select_out(rosc), .write_precompensation_out(write_precompensation),
        .margin_dac_out(margin), .erase_signal_disable_out(erase),
        .decoder_test_input_out(dtest), .precomp_bypass_out(pbyp), .encoder_bypass_out(ebyp),
        .test_mux_ctrl_out(mux), .compensated_write_valid_out(valid),
        .encoder_off_out(enc_off), .precomp_off_out(pc_off), .decoder_off_out(dec_off));
    cscp_ctrl_model ctrl_u (.clock_in(clock_in), .readback_in(rb), .readback_oe_in(rb_oe),
        .frame_select_n_out(sel_n), .data_out(sdata), .shift_clock_out(sclk));
    initial begin
        forever #10 clock_in = ~clock_in;
    end
    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] e;
        e = (a == REG_TEST_MUX) ? (d & MUX_USED_MASK) : d;
        ctrl_u.read_frame(a, bits, oe_on, oe_off);
        check("oe_on", 48'(oe_on), 48'h1);
        check("rd_bits", 48'(bits), 48'({a, e}));
        check("oe_off", 48'(oe_off), 48'h0);
    endtask
    task automatic settle();
        repeat (8) @(posedge clock_in);
    endtask
    initial begin
        #1000000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        settle();
        for (int r = 0; r < NUM_REGS; r++) begin
            rd_chk(4'(r), (r == 5) ? MUX_RESET_VAL : RESET_VAL);
        end
        $display("test reset_readback done");
        for (int r = 0; r < NUM_REGS; r++) begin
            ctrl_u.write_frame(4'(r), typ[r]);
        end
        ctrl_u.write_frame(4'h6, 8'h00);
        ctrl_u.idle_strobes();
        for (int r = 0; r < NUM_REGS; r++) begin
            rd_chk(4'(r), typ[r]);
        end
        check("typ_outs", 48'(obs), 48'(OBS_TYP));
        $display("test typical_program done");
        option_enable_n_in <= 1'b0;
        settle();
        check("opt_typ", 48'(obs), 48'(OBS_TYP));
        ctrl_u.write_frame(REG_DAC_TEST, 8'h10);
        ctrl_u.write_frame(REG_N_DIV_OSC, 8'h3E);
        ctrl_u.write_frame(REG_MARGIN, 8'h08);
        ctrl_u.write_frame(REG_TEST_MUX, 8'hAB);
        check("opt_on", 48'(obs), 48'(OBS_OPT));
        check("erase", 48'(erase), 48'h1);
        rd_chk(REG_TEST_MUX, 8'hAB);
        option_enable_n_in <= 1'b1;
        settle();
        check("opt_off", 48'(obs), 48'(OBS_TYP | 43'hA));
        $display("test option_controls done");
        for (int i = 0; i < 8; i++) begin
            low_power_request_n_in <= i[2];
            write_gate_n_in <= i[1];
            read_gate_n_in <= i[0];
            settle();
            check("enc_off", 48'(enc_off), 48'(!i[2] && i[1]));
            check("pc_off", 48'(pc_off), 48'(!i[2] && i[1]));
            check("dec_off", 48'(dec_off), 48'(!i[2] && i[0]));
        end
        low_power_request_n_in <= 1'b1;
        $display("test nap_modes done");
        sleep_in <= 1'b1;
        settle();
        check("valid_sleep", 48'(valid), 48'h0);
        ctrl_u.write_frame(REG_PRECOMP, 8'h55);
        sleep_in <= 1'b0;
        repeat (12) @(posedge clock_in);
        check("valid_early", 48'(valid), 48'h0);
        repeat (18) @(posedge clock_in);
        check("valid_late", 48'(valid), 48'h1);
        rd_chk(REG_PRECOMP, 8'h88);
        $display("test sleep_wake done");
        summarize();
    end
endmodule
